// ==== logic/wer_router.sv ====
/*
  Wake-up event router core: per-channel polarity, direct or latched
  mode, enable mask, write-one-to-clear of latched events, request lines
  to the vectored interrupt unit, clock-start requests and one summary
  interrupt. Assumes event inputs are level signals; internal sources
  sit at channels 22-24; registers are reached over AHB-Lite.
*/
`timescale 1ns/1ps
`default_nettype none
// Contract
// - 22 external plus 3 internal events routed
// - each event serves as interrupt or wake-up
// - per input, direct or edge-latched mode
// - direct request drops with the event
// - latched request holds until software clears
// - per input programmable level or edge polarity
// - per input mask keeps events from controller
// - detection and latching need no clock
// - bus sets polarity, mode and mask
// - detected event can request clock start
// - requests to interrupt unit active high
// - eight general inputs reset active high
// - serial receive and i2c clocks reset active low
module wer_router #(
  parameter int NCH = wer_pkg::NUM_CH
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RESETN,
  // ahb-lite register bus
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic HREADY,
  input wire logic [31:0] HWDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  // event sources
  input wire logic [wer_pkg::NUM_EXT-1:0] EXT_EVENT_INPUT,
  input wire logic [wer_pkg::NUM_INT-1:0] INT_EVENT_INPUT,
  // towards the vectored interrupt unit and clock control
  output logic [NCH-1:0] VECTORED_IRQ_UNIT_REQ,
  output logic [NCH-1:0] WAKE_REQ,
  output logic IRQ
);

  typedef struct packed {
    logic [NCH-1:0] ena;
    logic [NCH-1:0] pol;
    logic [NCH-1:0] mode;
    logic [NCH-1:0] kill;
    logic [NCH-1:0] req;
    logic irq;
  } wer_router_s;

  wer_router_s st_q, st_d;
  wer_reg_if rif ();

  logic [NCH-1:0] evt_raw;
  logic [NCH-1:0] evt_act;
  logic [NCH-1:0] lat_sync;
  logic [NCH-1:0] clr_req;
  logic [31:0] rd_val;

  // bus front end; all accesses take one wait state
  wer_ahb u_ahb (
    .clk(SYS_CLK),
    .resetn(RESETN),
    .hsel(HSEL),
    .haddr(HADDR),
    .htrans(HTRANS),
    .hwrite(HWRITE),
    .hsize(HSIZE),
    .hready(HREADY),
    .hwdata(HWDATA),
    .hreadyout(HREADYOUT),
    .hresp(HRESP),
    .hrdata(HRDATA),
    .rif(rif)
  );

  // gather all sources into one channel vector, internal ones on top
  assign evt_raw = {INT_EVENT_INPUT, EXT_EVENT_INPUT};

  // align each channel so that 1 means active; pure gating, no clock
  // polarity 1 passes the pin as is, polarity 0 inverts it
  assign evt_act = evt_raw ^ ~st_q.pol;

  // one edge latch per channel, each with its own crossing
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    wer_cell u_cell (
      .sys_clk(SYS_CLK),
      .resetn(RESETN),
      .evt_i(evt_act[i]),
      .kill_i(st_q.kill[i]),
      .latched_o(lat_sync[i]),
      .wake_o(WAKE_REQ[i])
    );
  end

  // write-one-to-clear on the status word touches only the written bits
  assign clr_req = (rif.we && rif.addr == wer_pkg::OFS_STATUS) ?
                   rif.wdata[NCH-1:0] : '0;

  // read multiplexer; unmapped offsets read as zero
  always_comb begin
    rd_val = 32'h00000000;
    case (rif.addr)
      wer_pkg::OFS_STATUS: rd_val[NCH-1:0] = lat_sync;
      wer_pkg::OFS_ENABLE: rd_val[NCH-1:0] = st_q.ena;
      wer_pkg::OFS_POLARITY: rd_val[NCH-1:0] = st_q.pol;
      wer_pkg::OFS_MODE: rd_val[NCH-1:0] = st_q.mode;
      wer_pkg::OFS_LEVEL: rd_val[NCH-1:0] = evt_act;
      wer_pkg::OFS_PENDING: rd_val[NCH-1:0] = st_q.req;
      default: rd_val = 32'h00000000;
    endcase
  end
  assign rif.rdata = rd_val;

  // next state: configuration writes, latch kill, request outputs
  always_comb begin
    st_d = st_q;
    if (rif.we) begin
      case (rif.addr)
        wer_pkg::OFS_ENABLE: st_d.ena = rif.wdata[NCH-1:0];
        wer_pkg::OFS_POLARITY: st_d.pol = rif.wdata[NCH-1:0];
        wer_pkg::OFS_MODE: st_d.mode = rif.wdata[NCH-1:0];
        default: st_d.ena = st_q.ena;
      endcase
    end
    // a latch is held clear while masked or in direct mode, so a stale
    // edge cannot surface later; kill comes from this flop, glitch-free
    st_d.kill = clr_req | ~(st_q.ena & st_q.mode);
    // direct channels follow the level, latched ones the held flag
    st_d.req = st_q.ena &
               ((st_q.mode & lat_sync) | (~st_q.mode & evt_act));
    st_d.irq = |st_d.req;
    if (!RESETN) begin
      st_d.ena = wer_pkg::ENA_RST;
      st_d.pol = wer_pkg::POL_RST;
      st_d.mode = wer_pkg::MODE_RST;
      st_d.kill = '1; // clear every latch while reset is held
      st_d.req = '0;
      st_d.irq = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    st_q <= st_d;
  end

  // request lines are active high, straight from flops
  assign VECTORED_IRQ_UNIT_REQ = st_q.req;
  assign IRQ = st_q.irq;

endmodule
`default_nettype wire

// ==== logic/wer_pkg.sv ====
/*
  Shared constants of the wake-up event router: channel counts, register
  byte offsets, reset values and the size of the crossing chain.
  Assumes a 32-bit AHB-Lite register bus and one system clock.
*/
`default_nettype none
package wer_pkg;

  // channel layout: external pins first, then the internal sources
  localparam int NUM_EXT = 22;
  localparam int NUM_INT = 3;
  localparam int NUM_CH = 25;

  // channel indices of the sources with an undefined documented polarity
  localparam int CH_USB_DP1 = 12;
  localparam int CH_USB_DP2 = 13;
  localparam int CH_USB_SCL1 = 21;

  // register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h04;
  localparam logic [7:0] OFS_POLARITY = 8'h08;
  localparam logic [7:0] OFS_MODE = 8'h0c;
  localparam logic [7:0] OFS_LEVEL = 8'h10;
  localparam logic [7:0] OFS_PENDING = 8'h14;

  // reset values: bit n belongs to channel n
  // polarity 1 = active high / rising edge; channels 0-7 and 22-24 high
  localparam logic [24:0] POL_RST = 25'h1c000ff;
  // enable: everything on except the three usb sources
  localparam logic [24:0] ENA_RST = 25'h1dfcfff;
  // mode 1 = latched (edge), 0 = direct (level)
  localparam logic [24:0] MODE_RST = 25'h0000000;

  // flip-flops in each latch-to-clock crossing
  localparam int SYNC_STAGES = 2;

endpackage
`default_nettype wire

// ==== logic/wer_reg_if.sv ====
/*
  Register access carrier between the bus front end and the router core:
  one-cycle write strobe with address and data, and the read value.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface wer_reg_if;
  logic we;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;

  // bus front end drives the access
  modport bus (output we, output addr, output wdata, input rdata);
  // router core holds the registers
  modport regs (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ==== logic/wer_cell.sv ====
/*
  One event channel: an edge latch clocked by the event itself, so it
  catches an edge with the system clock stopped, plus its crossing into
  the system clock. Assumes kill_i comes straight from a flip-flop.
*/
`timescale 1ns/1ps
`default_nettype none
module wer_cell #(
  parameter int STAGES = wer_pkg::SYNC_STAGES
) (
  // system side
  input wire logic sys_clk,
  input wire logic resetn,
  // event side: active level already aligned to polarity
  input wire logic evt_i,
  input wire logic kill_i,
  // results
  output logic latched_o,
  output logic wake_o
);

  typedef struct packed {
    logic [STAGES-1:0] sync;
  } wer_cell_s;

  wer_cell_s st_q, st_d;
  logic lat_q;

  // edge latch on the event itself; no system clock involved
  always_ff @(posedge evt_i or posedge kill_i) begin
    if (kill_i) begin
      lat_q <= 1'b0;
    end else begin
      lat_q <= 1'b1;
    end
  end

  // shift chain: first stage feeds only the second
  always_comb begin
    st_d = st_q;
    st_d.sync = {st_q.sync[STAGES-2:0], lat_q};
    if (!resetn) begin
      st_d.sync = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    st_q <= st_d;
  end

  assign latched_o = st_q.sync[STAGES-1];
  assign wake_o = lat_q; // usable as a clock-start request while stopped

endmodule
`default_nettype wire

// ==== logic/wer_ahb.sv ====
/*
  AHB-Lite slave front end: captures an address phase, inserts one wait
  state, then issues a one-cycle write strobe or captures read data.
  Assumes a single master, word transfers only, response always OKAY.
*/
`timescale 1ns/1ps
`default_nettype none
module wer_ahb (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // ahb-lite slave side
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // towards the register core
  wer_reg_if.bus rif
);

  typedef struct packed {
    logic pend;
    logic wr;
    logic [7:0] addr;
    logic ready;
    logic [31:0] rdata;
  } wer_ahb_s;

  wer_ahb_s st_q, st_d;
  logic unused_ok;

  assign unused_ok = ^{haddr[31:8], hsize};

  // address phase capture, then one wait state to register the answer
  always_comb begin
    st_d = st_q;
    if (st_q.pend) begin
      st_d.pend = 1'b0;
      st_d.ready = 1'b1;
      st_d.rdata = st_q.wr ? 32'h00000000 : rif.rdata;
    end else if (hsel && htrans[1] && hready) begin
      st_d.pend = 1'b1;
      st_d.wr = hwrite;
      st_d.addr = {haddr[7:2], 2'b00};
      st_d.ready = 1'b0;
    end
    if (!resetn) begin
      st_d.pend = 1'b0;
      st_d.wr = 1'b0;
      st_d.addr = 8'h00;
      st_d.ready = 1'b1;
      st_d.rdata = 32'h00000000;
    end
  end

  always_ff @(posedge clk) begin
    st_q <= st_d;
  end

  // write lands at the edge that ends the wait state, data is in hwdata
  assign rif.we = st_q.pend && st_q.wr;
  assign rif.addr = st_q.addr;
  assign rif.wdata = hwdata;
  assign hreadyout = st_q.ready;
  assign hresp = 1'b0;
  assign hrdata = st_q.rdata;

endmodule
`default_nettype wire

// ==== testbench/wer_monitor.sv ====
/* port checker of the event router, bound to wer_router
   assumes one clock; bus writes land one edge after the address */
`timescale 1ns/1ps
`default_nettype none
module wer_monitor #(parameter int NCH = 25) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RESETN,
  // register bus
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HWDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic [31:0] HRDATA,
  // events and requests
  input wire logic [21:0] EXT_EVENT_INPUT,
  input wire logic [2:0] INT_EVENT_INPUT,
  input wire logic [NCH-1:0] VECTORED_IRQ_UNIT_REQ,
  input wire logic [NCH-1:0] WAKE_REQ,
  input wire logic IRQ
);
  logic tk, pa_q, pw_q;
  logic [1:0] ok_q;
  logic [7:0] ad_q;
  logic [24:0] en_q, pol_q, md_q, dir;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  // config shadow; ok_q skips the edges where reset values still stand
  assign tk = HSEL && HTRANS[1] && HREADY;
  assign dir = ~({INT_EVENT_INPUT, EXT_EVENT_INPUT} ^ pol_q) & en_q & ~md_q;
  always_ff @(posedge SYS_CLK) begin
    ok_q <= {ok_q[0], RESETN};
    pa_q <= RESETN && tk;
    pw_q <= RESETN && tk && HWRITE;
    ad_q <= HADDR[7:0];
    if (!RESETN) begin
      en_q <= wer_pkg::ENA_RST;
      pol_q <= wer_pkg::POL_RST;
      md_q <= wer_pkg::MODE_RST;
    end else if (pw_q) begin
      if (ad_q == wer_pkg::OFS_ENABLE) en_q <= HWDATA[24:0];
      if (ad_q == wer_pkg::OFS_POLARITY) pol_q <= HWDATA[24:0];
      if (ad_q == wer_pkg::OFS_MODE) md_q <= HWDATA[24:0];
    end
  end
  a_resp_okay: assert property (HRESP == 1'h0)
    else $error("resp not okay");
  a_one_wait: assert property (tk |=> !HREADYOUT ##1 HREADYOUT)
    else $error("bad wait state");
  a_wait_short: assert property (!HREADYOUT |=> HREADYOUT)
    else $error("long wait");
  a_rdata_hold: assert property (!pa_q |=> $stable(HRDATA))
    else $error("read data moved");
  a_irq_or: assert property (IRQ == |VECTORED_IRQ_UNIT_REQ)
    else $error("irq mismatch");
  a_direct_follow: assert property (&ok_q |-> ((VECTORED_IRQ_UNIT_REQ
    ^ $past(dir)) & ~md_q & ~$past(md_q)) == '0)
    else $error("direct request wrong");
  a_req_masked: assert property (&ok_q |-> (VECTORED_IRQ_UNIT_REQ
    & ~en_q & ~$past(en_q)) == '0) else $error("masked request");
  a_wake_off: assert property (&ok_q |-> (WAKE_REQ & ~(en_q & md_q)
    & ~$past(en_q & md_q)) == '0) else $error("wake while off");
  cover property (tk && HWRITE);
  cover property ($rose(IRQ));
  cover property (|WAKE_REQ);
endmodule
bind wer_router wer_monitor #(.NCH(NCH)) u_wer_monitor (.SYS_CLK, .RESETN,
  .HSEL, .HADDR, .HTRANS, .HWRITE, .HREADY, .HWDATA, .HREADYOUT, .HRESP,
  .HRDATA, .EXT_EVENT_INPUT, .INT_EVENT_INPUT, .VECTORED_IRQ_UNIT_REQ,
  .WAKE_REQ, .IRQ);
`default_nettype wire

// ==== testbench/wer_partner.sv ====
/* partner model: the event pins feeding the router
   assumes the bench sets levels and pulses at clock edges */
`timescale 1ns/1ps
`default_nettype none
module wer_partner (
  // bench side
  input wire logic clk,
  input wire logic [24:0] lvl,
  input wire logic [24:0] pls,
  // pins toward the router
  output logic [21:0] ext,
  output logic [2:0] intv
);
  logic [24:0] pin = '0;
  assign {intv, ext} = pin;
  // a pulse is a 10 ns blip between edges: only a clockless latch sees it
  always @(posedge clk) begin
    pin <= lvl;
    #15 pin = lvl ^ pls;
    #10 pin = lvl;
  end
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
/* self-checking bench of the event router
   assumes the partner model drives every event pin */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
module testbench;
  logic SYS_CLK = 1'h0, RESETN = 1'h0, HSEL = 1'h0, HWRITE = 1'h0;
  logic [31:0] HADDR = '0, HWDATA = '0, HRDATA, x, s = 32'h00003e8c;
  logic [1:0] HTRANS = 2'h0;
  logic HREADYOUT, HRESP, IRQ, rp = 1'h0;
  logic [21:0] EXT_EVENT_INPUT;
  logic [2:0] INT_EVENT_INPUT;
  logic [24:0] VECTORED_IRQ_UNIT_REQ, WAKE_REQ, p, e, l, pls = '0;
  logic [24:0] lvl = ~wer_pkg::POL_RST;
  logic [31:0] q[$];
  int fails = 0, checks_done = 0;
  always #20 SYS_CLK = ~SYS_CLK;
  wer_router u_wer_router (.SYS_CLK, .RESETN, .HSEL, .HADDR, .HTRANS,
    .HWRITE, .HSIZE(3'h2), .HREADY(HREADYOUT), .HWDATA, .HREADYOUT,
    .HRESP, .HRDATA, .EXT_EVENT_INPUT, .INT_EVENT_INPUT,
    .VECTORED_IRQ_UNIT_REQ, .WAKE_REQ, .IRQ);
  wer_partner u_wer_partner (.clk(SYS_CLK), .lvl(lvl), .pls(pls),
    .ext(EXT_EVENT_INPUT), .intv(INT_EVENT_INPUT));
  // xorshift source for levels, polarities and masks
  function automatic logic [24:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s[24:0];
  endfunction
  // one single word transfer; the bus may stretch either phase
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [24:0] d);
    HSEL <= 1'h1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {24'h0, a};
    do @(posedge SYS_CLK); while (!HREADYOUT);
    HSEL <= 1'h0;
    HTRANS <= 2'h0;
    HWDATA <= {7'h0, d};
    do @(posedge SYS_CLK); while (!HREADYOUT);
  endtask
  // a read notes its expected word before it starts
  task automatic rd(input logic [7:0] a, input logic [24:0] d);
    q.push_back({7'h0, d});
    xfer(1'h0, a, '0);
  endtask
  // read watcher: oldest note against data standing at completion
  always @(posedge SYS_CLK) begin
    if (rp && HREADYOUT) begin
      x = q.pop_front();
      `CHK(HRDATA, x)
      rp = 1'h0;
    end
    if (HSEL && HTRANS[1] && HREADYOUT && !HWRITE) rp = 1'h1;
  end
  // counts, verdict and end of run
  task automatic print_verdict();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // watchdog: the tests need a few hundred cycles
  initial begin
    #100000;
    fails++;
    print_verdict();
  end
  // reset values, random direct traffic, then latched capture and clear
  initial begin
    repeat (5) @(posedge SYS_CLK);
    RESETN <= 1'h1;
    rd(wer_pkg::OFS_ENABLE, 25'h1dfcfff);
    rd(wer_pkg::OFS_POLARITY, 25'h1c000ff);
    rd(wer_pkg::OFS_MODE, '0);
    rd(8'h18, '0);
    for (int i = 0; i < 8; i++) begin
      p = rnd();
      e = rnd();
      l = rnd();
      xfer(1'h1, wer_pkg::OFS_POLARITY, p);
      xfer(1'h1, wer_pkg::OFS_ENABLE, e);
      lvl <= l;
      repeat (3) @(posedge SYS_CLK);
      rd(wer_pkg::OFS_POLARITY, p);
      rd(wer_pkg::OFS_ENABLE, e);
      rd(wer_pkg::OFS_LEVEL, ~(l ^ p));
      rd(wer_pkg::OFS_PENDING, ~(l ^ p) & e);
      `CHK(IRQ, |(~(l ^ p) & e))
    end
    xfer(1'h1, wer_pkg::OFS_POLARITY, 25'h1ffffff);
    xfer(1'h1, wer_pkg::OFS_ENABLE, 25'h1ffffdf);
    lvl <= '0;
    xfer(1'h1, wer_pkg::OFS_MODE, 25'h1ffffff);
    xfer(1'h1, wer_pkg::OFS_STATUS, 25'h1ffffff);
    repeat (3) @(posedge SYS_CLK);
    pls <= 25'h0400028;
    #30 `CHK(WAKE_REQ, 25'h0400008)
    @(posedge SYS_CLK);
    pls <= '0;
    repeat (4) @(posedge SYS_CLK);
    rd(wer_pkg::OFS_STATUS, 25'h0400008);
    rd(wer_pkg::OFS_PENDING, 25'h0400008);
    xfer(1'h1, wer_pkg::OFS_STATUS, 25'h0000008);
    repeat (4) @(posedge SYS_CLK);
    rd(wer_pkg::OFS_PENDING, 25'h0400000);
    `CHK(WAKE_REQ, 25'h0400000)
    xfer(1'h1, wer_pkg::OFS_STATUS, 25'h0400000);
    repeat (4) @(posedge SYS_CLK);
    `CHK(IRQ, 1'h0)
    print_verdict();
  end
endmodule
`default_nettype wire
